// file: logic/posopt_pkg.sv
// Constants, field layouts and carrier types for the positioning-option and slippage monitor.
// Assumes one 50 MHz control clock; the object port is a simple index/data strobe interface.
package posopt_pkg;
   localparam logic [15:0] IDX_OPTION    = 16'h60f2;
   localparam logic [15:0] IDX_FOLLOW    = 16'h60f4;
   localparam logic [15:0] IDX_SLIP_MAX  = 16'h60f8;
   localparam logic [15:0] IDX_EFFORT    = 16'h60fa;
   localparam logic [15:0] OPTION_RESET  = 16'h0001;
   localparam logic [31:0] SLIP_RESET    = 32'h00000190;
   localparam logic [31:0] SLIP_OFF      = 32'h7fffffff;
   localparam logic [1:0]  CODE_00       = 2'h0;
   localparam logic [1:0]  CODE_01       = 2'h1;
   localparam logic [1:0]  CODE_10       = 2'h2;
   localparam logic [1:0]  CODE_11       = 2'h3;
   localparam int          HIST_DEPTH    = 8;
   localparam int          HIST_AW       = 3;

   // Option word layout, most significant field first.
   typedef struct packed {
      logic       vendor_specific_top_bit;
      logic [2:0] reserved;
      logic [3:0] interpolation_flags;
      logic [1:0] rotary_direction_select;
      logic [1:0] setpoint_auto_release;
      logic [1:0] spare_option;
      logic [1:0] relative_move_reference;
   } option_word_t;

   // Motion measurements supplied by the drive core each cycle.
   typedef struct packed {
      logic [31:0] actual_position;
      logic [31:0] ramp_output;
      logic [31:0] actual_speed;
      logic [31:0] set_speed;
      logic [31:0] demand_increments;
   } motion_in_t;

   typedef enum logic [1:0] {
      MODE_OTHER,
      MODE_PROFILE_POSITION,
      MODE_PROFILE_VELOCITY
   } op_mode_t;

   typedef enum {
      HS_IDLE,
      HS_ACK,
      HS_RELEASED
   } handshake_t;
endpackage

// file: logic/error_history_mem.sv
// Small memory holding the error history; read data comes out of a register.
// Assumes writes and reads from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module error_history_mem
   import posopt_pkg::*;
#(
   parameter int DEPTH = HIST_DEPTH,
   parameter int AW    = HIST_AW,
   parameter int DW    = 16
) (
   // Clock and reset.
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Write port.
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   // Read port.
   input  wire logic [AW-1:0] rd_addr,
   output var  logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem [DEPTH];
   logic [DW-1:0] rd_data_d;

   // Registered read gives a one-cycle latency.
   always_comb begin
      rd_data_d = mem[rd_addr];
   end

   // Storage has no reset; the read register does.
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (!rst_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= rd_data_d;
      end
   end
endmodule
`default_nettype wire

// file: logic/positioning_option_slippage_monitor.sv
// Positioning options, setpoint handshake release, rotary direction and slippage supervision.
// Assumes the drive core supplies measurements on REF_CLK and the master uses the object port.
`timescale 1ns/1ps
`default_nettype none
module positioning_option_slippage_monitor
   import posopt_pkg::*;
#(
   parameter logic [31:0] MODULO     = 32'h00010000,
   parameter logic [31:0] RANGE_MIN  = 32'h00000000,
   parameter logic [31:0] RANGE_MAX  = 32'h0000ffff,
   parameter logic [31:0] SLIP_DELAY = 32'h00000064,
   parameter int          KP_SHIFT   = 2,
   parameter int          KI_SHIFT   = 8,
   parameter logic [15:0] SLIP_CODE  = 16'h8611
) (
   // Clock and reset.
   input  wire logic         REF_CLK,
   input  wire logic         RST_N,
   // Object access port.
   input  wire logic         OBJ_WR,
   input  wire logic [15:0]  OBJ_INDEX,
   input  wire logic [31:0]  OBJ_WDATA,
   output var  logic [31:0]  OBJ_RDATA,
   output var  logic         OBJ_RVALID,
   output var  logic         OBJ_UNMAPPED,
   // Control word bits and mode.
   input  wire op_mode_t     MODE,
   input  wire logic         NEW_SETPOINT_SET,
   input  wire logic         NEW_SETPOINT_CLR,
   input  wire logic         RELATIVE_MOVE,
   input  wire logic [31:0]  TARGET_POSITION,
   input  wire logic         TARGET_REACHED,
   input  wire logic         SLIP_REACTION_EN,
   input  wire motion_in_t   MOTION,
   // Error history read-back.
   input  wire logic [2:0]   HIST_RD_ADDR,
   output var  logic [15:0]  HIST_RD_DATA,
   // Status and outputs.
   output var  logic         NEW_SETPOINT,
   output var  logic         SETPOINT_ACK,
   output var  logic         SLIPPAGE,
   output var  logic [31:0]  POSITION_DEMAND,
   output var  logic         MOVE_NEGATIVE,
   output var  logic [31:0]  CORRECTION_SPEED,
   output var  logic [31:0]  DEMAND_INCREMENTS
);
   // Register state.
   option_word_t opt_q, opt_d;
   logic [31:0]  slip_max_q, slip_max_d;
   logic [31:0]  rdata_d;
   logic         rvalid_d, unmapped_d;
   logic [31:0]  prev_target_q, prev_target_d;
   logic [31:0]  demand_q, demand_d;
   logic         neg_q, neg_d;
   logic [31:0]  ferr_q, ferr_d;
   logic [31:0]  integ_q, integ_d;
   logic [31:0]  effort_q, effort_d;
   logic [31:0]  incr_q, incr_d;
   handshake_t   hs_q, hs_d;
   logic         nsp_q, nsp_d, ack_q, ack_d;
   logic [31:0]  slip_cnt_q, slip_cnt_d;
   logic         slip_q, slip_d;
   logic [2:0]   hist_ptr_q, hist_ptr_d;
   logic         hist_we;

   // Magnitude of a signed word; used for speed error and limit.
   // The most negative word maps onto itself and still compares above the largest
   // positive limit, so only the disable code or a limit of the most negative word can switch supervision off.
   function automatic logic [31:0] abs32(input logic [31:0] v);
      abs32 = v[31] ? (~v + 32'h00000001) : v;
   endfunction

   // Wrap a value into the range limits.
   // Only one modulo step is taken; a value more than one turn outside is not folded fully.
   function automatic logic [31:0] wrap_range(input logic [31:0] v);
      if ($signed(v) > $signed(RANGE_MAX)) begin
         wrap_range = v - MODULO;
      end else if ($signed(v) < $signed(RANGE_MIN)) begin
         wrap_range = v + MODULO;
      end else begin
         wrap_range = v;
      end
   endfunction

   // Object writes and reads; reserved option bits are stored but act on nothing.
   // Every cycle without a write counts as a read, so the answer register holds the
   // object presented last cycle, or zero after an unmapped index or an option or
   // slip-limit write; the master ignores it unless it asked.
   always_comb begin
      opt_d      = opt_q;
      slip_max_d = slip_max_q;
      rdata_d    = 32'h00000000;
      rvalid_d   = 1'b0;
      unmapped_d = 1'b0;
      if (OBJ_INDEX == IDX_OPTION) begin
         if (OBJ_WR) begin
            opt_d = option_word_t'(OBJ_WDATA[15:0]);
         end else begin
            rdata_d  = {16'h0000, opt_q};
            rvalid_d = 1'b1;
         end
      end else if (OBJ_INDEX == IDX_SLIP_MAX) begin
         if (OBJ_WR) begin
            slip_max_d = OBJ_WDATA;
         end else begin
            rdata_d  = slip_max_q;
            rvalid_d = 1'b1;
         end
      end else if (OBJ_INDEX == IDX_FOLLOW) begin
         rdata_d  = ferr_q;
         rvalid_d = !OBJ_WR;
      end else if (OBJ_INDEX == IDX_EFFORT) begin
         rdata_d  = effort_q;
         rvalid_d = !OBJ_WR;
      end else begin
         unmapped_d = 1'b1;
      end
   end

   // Target computation and rotary direction choice.
   // The previous target moves on every set strobe in profile position mode, taken by the
   // handshake or not, so code 00 keeps chaining relative moves across mode changes.
   always_comb begin
      logic [31:0] base;
      logic [31:0] tgt;
      logic [31:0] diff;
      base          = 32'h00000000;
      tgt           = TARGET_POSITION;
      diff          = 32'h00000000;
      prev_target_d = prev_target_q;
      demand_d      = demand_q;
      neg_d         = neg_q;
      if (NEW_SETPOINT_SET && MODE == MODE_PROFILE_POSITION) begin
         if (RELATIVE_MOVE) begin
            case (opt_q.relative_move_reference)
               CODE_00: base = prev_target_q;
               CODE_01: base = MOTION.ramp_output;
               CODE_10: base = MOTION.actual_position;
               default: base = prev_target_q;
            endcase
            tgt = base + TARGET_POSITION;
         end
         prev_target_d = tgt;
         diff = tgt - MOTION.actual_position;
         case (opt_q.rotary_direction_select)
            CODE_00: begin
               demand_d = wrap_range(tgt);
               neg_d    = diff[31];
            end
            CODE_01: begin
               demand_d = wrap_range(tgt);
               neg_d    = 1'b1;
            end
            CODE_10: begin
               demand_d = wrap_range(tgt);
               neg_d    = 1'b0;
            end
            default: begin
               demand_d = wrap_range(tgt);
               neg_d    = !($signed(wrap_range(diff + MODULO)) < $signed(MODULO >> 1));
            end
         endcase
      end
   end

   // Position loop: following error and PI correction speed.
   // Both terms are kept signed; an unsigned sum would turn a negative error into
   // a huge positive integral step. The integral is not clamped and wraps if an
   // error stands for very long.
   always_comb begin
      ferr_d   = demand_q - MOTION.actual_position;
      integ_d  = 32'($signed(integ_q) + ($signed(ferr_q) >>> KI_SHIFT));
      effort_d = 32'(($signed(ferr_q) <<< KP_SHIFT) + $signed(integ_q));
      incr_d   = MOTION.demand_increments;
   end

   // New-setpoint handshake with optional automatic release.
   // Reserved code 11 never releases. A set request that arrives while a release
   // is still being reported is not taken, so the master must wait for the acknowledge to drop.
   always_comb begin
      hs_d  = hs_q;
      nsp_d = nsp_q;
      ack_d = ack_q;
      case (hs_q)
         HS_IDLE: begin
            if (NEW_SETPOINT_SET) begin
               nsp_d = 1'b1;
               ack_d = 1'b1;
               hs_d  = HS_ACK;
            end
         end
         HS_ACK: begin
            if (opt_q.setpoint_auto_release == CODE_10) begin
               nsp_d = 1'b0;
               hs_d  = HS_RELEASED;
            end else if (opt_q.setpoint_auto_release == CODE_01 && TARGET_REACHED) begin
               nsp_d = 1'b0;
               hs_d  = HS_RELEASED;
            end else if (opt_q.setpoint_auto_release == CODE_00 && NEW_SETPOINT_CLR) begin
               nsp_d = 1'b0;
               ack_d = 1'b0;
               hs_d  = HS_IDLE;
            end
         end
         default: begin
            ack_d = 1'b0;
            hs_d  = HS_IDLE;
         end
      endcase
   end

   // Slippage supervision; only a sustained excess raises the bit.
   // The counter stops one past the delay, so a long excess cannot wrap it
   // and drop the bit by mistake.
   always_comb begin
      logic excess;
      excess     = abs32(MOTION.actual_speed - MOTION.set_speed) > abs32(slip_max_q);
      slip_cnt_d = 32'h00000000;
      slip_d     = 1'b0;
      hist_ptr_d = hist_ptr_q;
      if (MODE == MODE_PROFILE_VELOCITY && slip_max_q != SLIP_OFF && excess) begin
         slip_cnt_d = (slip_cnt_q > SLIP_DELAY) ? slip_cnt_q : slip_cnt_q + 32'h00000001;
         slip_d     = slip_cnt_q > SLIP_DELAY;
      end
      hist_we = slip_d && !slip_q && SLIP_REACTION_EN;
      if (hist_we) begin
         hist_ptr_d = hist_ptr_q + 3'h1;
      end
   end

   // History entries carry a fixed code; the write pointer simply wraps round.
   error_history_mem #(
      .DEPTH (HIST_DEPTH),
      .AW    (HIST_AW),
      .DW    (16)
   ) u_hist (
      .clk     (REF_CLK),
      .rst_n   (RST_N),
      .wr_en   (hist_we),
      .wr_addr (hist_ptr_q),
      .wr_data (SLIP_CODE),
      .rd_addr (HIST_RD_ADDR),
      .rd_data (HIST_RD_DATA)
   );

   // All state registers; synchronous reset.
   // A reset pulse shorter than one clock period is not seen.
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         opt_q         <= option_word_t'(OPTION_RESET);
         slip_max_q    <= SLIP_RESET;
         OBJ_RDATA     <= 32'h00000000;
         OBJ_RVALID    <= 1'b0;
         OBJ_UNMAPPED  <= 1'b0;
         prev_target_q <= 32'h00000000;
         demand_q      <= 32'h00000000;
         neg_q         <= 1'b0;
         ferr_q        <= 32'h00000000;
         integ_q       <= 32'h00000000;
         effort_q      <= 32'h00000000;
         incr_q        <= 32'h00000000;
         hs_q          <= HS_IDLE;
         nsp_q         <= 1'b0;
         ack_q         <= 1'b0;
         slip_cnt_q    <= 32'h00000000;
         slip_q        <= 1'b0;
         hist_ptr_q    <= 3'h0;
      end else begin
         opt_q         <= opt_d;
         slip_max_q    <= slip_max_d;
         OBJ_RDATA     <= rdata_d;
         OBJ_RVALID    <= rvalid_d;
         OBJ_UNMAPPED  <= unmapped_d;
         prev_target_q <= prev_target_d;
         demand_q      <= demand_d;
         neg_q         <= neg_d;
         ferr_q        <= ferr_d;
         integ_q       <= integ_d;
         effort_q      <= effort_d;
         incr_q        <= incr_d;
         hs_q          <= hs_d;
         nsp_q         <= nsp_d;
         ack_q         <= ack_d;
         slip_cnt_q    <= slip_cnt_d;
         slip_q        <= slip_d;
         hist_ptr_q    <= hist_ptr_d;
      end
   end

   // Outputs straight from flip-flops.
   // No logic sits between a register and its pin, so every output is glitch free.
   always_comb begin
      NEW_SETPOINT      = nsp_q;
      SETPOINT_ACK      = ack_q;
      SLIPPAGE          = slip_q;
      POSITION_DEMAND   = demand_q;
      MOVE_NEGATIVE     = neg_q;
      CORRECTION_SPEED  = effort_q;
      DEMAND_INCREMENTS = incr_q;
   end
endmodule
`default_nettype wire

// file: bench/posopt_master_model.sv
// Fieldbus master model: object writes and reads plus the new-setpoint strobes.
// Assumes the bench clock; every request changes 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module posopt_master_model
   import posopt_pkg::*;
(
   // Clock.
   input  wire logic        clk,
   // Object port towards the drive.
   output var  logic        obj_wr,
   output var  logic [15:0] obj_index,
   output var  logic [31:0] obj_wdata,
   input  wire logic [31:0] obj_rdata,
   // Setpoint strobes.
   output var  logic        sp_set,
   output var  logic        sp_clr
);
   // Idle is an option-word read, since every non-write cycle counts as a read.
   initial begin
      obj_wr = 1'b0;
      obj_index = IDX_OPTION;
      obj_wdata = 32'h0;
      sp_set = 1'b0;
      sp_clr = 1'b0;
   end

   // One write; callers keep the reference and release option fields below code 11.
   task automatic wr(input logic [15:0] idx, input logic [31:0] dv);
      @(posedge clk) #1;
      obj_wr = 1'b1;
      obj_index = idx;
      obj_wdata = dv;
      @(posedge clk) #1;
      obj_wr = 1'b0;
      obj_index = IDX_OPTION;
      obj_wdata = ~dv;  // Released data does not keep the old value.
   endtask

   // One read; the answer stands for the cycle after the index is taken.
   task automatic rd(input logic [15:0] idx, output logic [31:0] dv);
      @(posedge clk) #1;
      obj_index = idx;
      @(posedge clk) #1;
      dv = obj_rdata;
      obj_index = IDX_OPTION;
   endtask

   // A one-cycle strobe; the clear strobe is how the master ends a handshake itself.
   task automatic pulse(input logic clr);
      @(posedge clk) #1;
      sp_set = !clr;
      sp_clr = clr;
      @(posedge clk) #1;
      sp_set = 1'b0;
      sp_clr = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: bench/positioning_option_slippage_monitor_checker.sv
// Concurrent checks on the monitor's ports, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module positioning_option_slippage_monitor_checker
   import posopt_pkg::*;
#(
   parameter logic [31:0] SLIP_DELAY = 32'h00000064
) (
   // Clock, reset and object port.
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   input wire logic        OBJ_WR,
   input wire logic [15:0] OBJ_INDEX,
   input wire logic [31:0] OBJ_WDATA,
   input wire logic [31:0] OBJ_RDATA,
   input wire logic        OBJ_RVALID,
   input wire logic        OBJ_UNMAPPED,
   // Motion side and status.
   input wire op_mode_t    MODE,
   input wire logic        NEW_SETPOINT_SET,
   input wire motion_in_t  MOTION,
   input wire logic        NEW_SETPOINT,
   input wire logic        SETPOINT_ACK,
   input wire logic        SLIPPAGE
);
   logic [31:0] lim_q;
   logic [31:0] cnt_q;
   logic [31:0] diff;
   logic        excess;
   logic        mapped;

   // Mirror of the slip limit and a count of consecutive excess cycles.
   assign mapped = OBJ_INDEX inside {IDX_OPTION, IDX_FOLLOW, IDX_SLIP_MAX, IDX_EFFORT};
   assign diff = MOTION.actual_speed - MOTION.set_speed;
   assign excess = MODE == MODE_PROFILE_VELOCITY && lim_q != SLIP_OFF && (diff[31] ? -diff : diff) > lim_q;
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         lim_q <= SLIP_RESET;
         cnt_q <= 32'h0;
      end else begin
         lim_q <= (OBJ_WR && OBJ_INDEX == IDX_SLIP_MAX) ? OBJ_WDATA : lim_q;
         cnt_q <= excess ? cnt_q + 32'h1 : 32'h0;
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   // Object port, handshake and slippage relations.
   a_unmapped_flag: assert property (!mapped |=> OBJ_UNMAPPED) else $error("unmapped index not flagged");
   a_read_valid: assert property (!OBJ_WR && mapped |=> OBJ_RVALID && !OBJ_UNMAPPED) else $error("no read answer");
   a_option_upper: assert property (!OBJ_WR && OBJ_INDEX == IDX_OPTION |=> OBJ_RDATA[31:16] == 16'h0)
      else $error("option word upper half not zero");
   a_ack_follows_set: assert property (NEW_SETPOINT_SET |=> NEW_SETPOINT && SETPOINT_ACK)
      else $error("setpoint not acknowledged");
   a_setpoint_cause: assert property ($rose(NEW_SETPOINT) |-> $past(NEW_SETPOINT_SET))
      else $error("setpoint rose without request");
   a_ack_release: assert property ($fell(NEW_SETPOINT) |=> !SETPOINT_ACK) else $error("acknowledge kept");
   a_slip_delay: assert property ($rose(SLIPPAGE) |-> cnt_q > SLIP_DELAY) else $error("slippage too early");
   a_slip_drops: assert property (!excess |=> !SLIPPAGE) else $error("slippage without excess");
   a_slip_hold: assert property (SLIPPAGE && excess |=> SLIPPAGE) else $error("slippage dropped");
   a_slip_off: assert property (lim_q == SLIP_OFF |-> ##1 !SLIPPAGE) else $error("supervision not off");

   c_slip_rise: cover property ($rose(SLIPPAGE));
   c_unmapped: cover property (OBJ_UNMAPPED);
   c_release: cover property ($fell(NEW_SETPOINT));
endmodule

bind positioning_option_slippage_monitor positioning_option_slippage_monitor_checker #(.SLIP_DELAY(SLIP_DELAY)) u_chk (
   .REF_CLK(REF_CLK), .RST_N(RST_N), .OBJ_WR(OBJ_WR), .OBJ_INDEX(OBJ_INDEX), .OBJ_WDATA(OBJ_WDATA),
   .OBJ_RDATA(OBJ_RDATA), .OBJ_RVALID(OBJ_RVALID), .OBJ_UNMAPPED(OBJ_UNMAPPED), .MODE(MODE),
   .NEW_SETPOINT_SET(NEW_SETPOINT_SET), .MOTION(MOTION), .NEW_SETPOINT(NEW_SETPOINT),
   .SETPOINT_ACK(SETPOINT_ACK), .SLIPPAGE(SLIPPAGE));
`default_nettype wire

// file: bench/positioning_option_slippage_monitor_tb_top.sv
// Self-checking bench: reference model in integers against the monitor.
// Assumes the master model drives the object port; the bench drives motion inputs.
`timescale 1ns/1ps
`default_nettype none
module positioning_option_slippage_monitor_tb_top;
   import posopt_pkg::*;
   localparam logic [31:0] SD = 32'h4;
   localparam logic [15:0] HCODE = 16'h5a3c;  // Arbitrary history code.
   logic clk = 1'b0;
   logic rst_n, rel, trg, slip_en, obj_wr, sp_set, sp_clr, unm, ns, ack, slip, neg;
   op_mode_t mode;
   motion_in_t mot;
   logic [15:0] obj_index, hist_d;
   logic [31:0] obj_wdata, obj_rdata, tgt, d, t, base, prev, pdem, dinc, eff;
   logic [2:0] hist_a;
   logic [15:0] idx_t [4] = '{IDX_OPTION, IDX_FOLLOW, IDX_SLIP_MAX, IDX_EFFORT};
   logic [31:0] rst_t [4] = '{32'h1, 32'h0, SLIP_RESET, 32'h0};
   logic [1:0] rc [4] = '{CODE_00, CODE_00, CODE_01, CODE_10};
   int errors, n_tests, seed, k;
   int m_ferr, m_integ, m_eff, m_eff_q;
   localparam int KP = 2;  // Gains kept at the design's default shifts.
   localparam int KI = 8;

   always #10 clk = ~clk;

   // Reference position loop: proportional and integral action on the following error.
   always @(posedge clk) begin
      if (rst_n !== 1'b1) begin
         m_ferr <= 0;
         m_integ <= 0;
         m_eff <= 0;
         m_eff_q <= 0;
      end else begin
         m_ferr <= int'(pdem - mot.actual_position);
         m_integ <= m_integ + (m_ferr >>> KI);
         m_eff <= (m_ferr <<< KP) + m_integ;
         m_eff_q <= m_eff;
      end
   end

   positioning_option_slippage_monitor #(.SLIP_DELAY(SD), .SLIP_CODE(HCODE)) u_dut (
      .REF_CLK(clk), .RST_N(rst_n), .OBJ_WR(obj_wr), .OBJ_INDEX(obj_index), .OBJ_WDATA(obj_wdata),
      .OBJ_RDATA(obj_rdata), .OBJ_RVALID(), .OBJ_UNMAPPED(unm), .MODE(mode), .NEW_SETPOINT_SET(sp_set),
      .NEW_SETPOINT_CLR(sp_clr), .RELATIVE_MOVE(rel), .TARGET_POSITION(tgt), .TARGET_REACHED(trg),
      .SLIP_REACTION_EN(slip_en), .MOTION(mot), .HIST_RD_ADDR(hist_a), .HIST_RD_DATA(hist_d),
      .NEW_SETPOINT(ns), .SETPOINT_ACK(ack), .SLIPPAGE(slip), .POSITION_DEMAND(pdem), .MOVE_NEGATIVE(neg),
      .CORRECTION_SPEED(eff), .DEMAND_INCREMENTS(dinc));
   posopt_master_model u_master (.clk(clk), .obj_wr(obj_wr), .obj_index(obj_index), .obj_wdata(obj_wdata),
      .obj_rdata(obj_rdata), .sp_set(sp_set), .sp_clr(sp_clr));

   // Compare one result and count it.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Expected direction for an absolute move; half a turn is half the modulo.
   function automatic logic neg_exp(input logic [1:0] c, input logic [31:0] cur, input logic [31:0] tv);
      case (c)
         CODE_00: neg_exp = tv < cur;
         CODE_01: neg_exp = 1'b1;
         CODE_10: neg_exp = 1'b0;
         default: neg_exp = ((tv - cur) & 32'hffff) >= 32'h8000;
      endcase
   endfunction

   // Issue a setpoint and check demand, and direction when use_n is set; release is left to code 10.
   task automatic move(input logic [31:0] tv, input logic [31:0] ed, input logic en, input logic use_n);
      tgt = tv;
      u_master.pulse(1'b0);
      @(posedge clk) #1;
      chk(pdem, ed);
      if (use_n) chk(32'(neg), 32'(en));
      repeat (3) @(posedge clk) #1;
   endtask

   // Bounded wait for the drive to drop the new-setpoint bit.
   task automatic wait_lo();
      for (int i = 0; i < 4 && ns !== 1'b0; i++) @(posedge clk) #1;
      chk(32'(ns), 32'h0);
   endtask

   initial begin
      #400000;
      errors++;
      print_verdict();
   end

   initial begin
      seed = 70;
      rst_n = 1'b0;
      mode = MODE_OTHER;
      {rel, trg, slip_en, tgt, mot, hist_a} = '0;
      slip_en = 1'b1;
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      // Reset values, a refused write to a read-only object, an unmapped index.
      for (k = 0; k < 4; k++) begin
         u_master.rd(idx_t[k], d);
         chk(d, rst_t[k]);
      end
      u_master.wr(IDX_EFFORT, 32'h1234);
      u_master.rd(IDX_EFFORT, d);
      chk(d, 32'h0);
      u_master.rd(16'h60f3, d);
      chk(32'(unm), 32'h1);
      d = $random(seed) & 32'hffdd;
      u_master.wr(IDX_OPTION, d);
      u_master.rd(IDX_OPTION, t);
      chk(t & 32'hffff0fff, d & 32'h0fff);
      // Relative moves under reference codes 00, 01 and 10.
      mode = MODE_PROFILE_POSITION;
      rel = 1'b1;
      prev = 32'h0;
      for (k = 0; k < 4; k++) begin
         u_master.wr(IDX_OPTION, {26'h0, 2'b10, 2'b00, rc[k]});
         mot.ramp_output = $random(seed) & 32'hff;
         mot.actual_position = $random(seed) & 32'hff;
         t = $random(seed) & 32'hff;
         base = (rc[k] == CODE_00) ? prev : (rc[k] == CODE_01) ? mot.ramp_output : mot.actual_position;
         move(t, base + t, 1'b0, 1'b0);
         prev = base + t;
      end
      // Absolute moves: reference field ignored, every direction code.
      rel = 1'b0;
      for (k = 0; k < 16; k++) begin
         u_master.wr(IDX_OPTION, {24'h0, 2'(k), 4'h8, 2'(k % 3)});
         mot.actual_position = prev;
         mot.ramp_output = prev;
         t = $random(seed) & 32'hffff;
         if (t == prev) t = t ^ 32'h1;
         move(t, t, neg_exp(2'(k), prev, t), 1'b1);
         prev = t;
      end
      mot.actual_position = prev + 32'h20;
      mot.demand_increments = $random(seed);
      repeat (2) @(posedge clk) #1;
      chk(dinc, mot.demand_increments);
      u_master.rd(IDX_FOLLOW, d);
      chk(d, 32'hffffffe0);
      u_master.rd(IDX_EFFORT, d);
      chk(d, 32'(m_eff_q));
      chk(eff, 32'(m_eff));
      // Handshake release under codes 10, 01 and 00.
      u_master.wr(IDX_OPTION, 32'h20);
      u_master.pulse(1'b0);
      wait_lo();
      chk(32'(ack), 32'h1);
      @(posedge clk) #1;
      chk(32'(ack), 32'h0);
      u_master.wr(IDX_OPTION, 32'h10);
      u_master.pulse(1'b0);
      repeat (5) @(posedge clk) #1;
      chk(32'(ns), 32'h1);
      trg = 1'b1;
      wait_lo();
      u_master.wr(IDX_OPTION, 32'h0);
      u_master.pulse(1'b0);
      repeat (6) @(posedge clk) #1;
      chk(32'(ns), 32'h1);
      u_master.pulse(1'b1);
      chk(32'({ns, ack}), 32'h0);
      // Slippage above and below the set speed, then supervision off.
      mode = MODE_PROFILE_VELOCITY;
      u_master.wr(IDX_SLIP_MAX, 32'h10);
      mot.set_speed = 32'h100;
      for (k = 0; k < 2; k++) begin
         mot.actual_speed = k ? 32'he0 : 32'h120;
         repeat (SD) @(posedge clk) #1;
         chk(32'(slip), 32'h0);
         repeat (4) @(posedge clk) #1;
         chk(32'(slip), 32'h1);
         mot.actual_speed = 32'h100;
         hist_a = 3'(k);
         @(posedge clk) #1;
         chk(32'(slip), 32'h0);
         chk(32'(hist_d), 32'(HCODE));
      end
      u_master.wr(IDX_SLIP_MAX, SLIP_OFF);
      mot.actual_speed = 32'h80000100;
      repeat (SD + 6) @(posedge clk) #1;
      chk(32'(slip), 32'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
